// [ttc_timer_unit.sv]
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - mode 0 counts high byte plus low five bits of low byte, 13 bits.
// - a wrap from all ones to all zeros sets the overflow flag.
// - outside timer 0 split, counting only while run is 1 and gate is 0 or gate pin high.
// - setting run leaves the count registers untouched.
// - mode 1 is mode 0 with the full 16-bit count.
// - mode 2 counts low byte, reloads it from high byte on overflow.
// - timer 1 in mode 3 holds its count as if stopped.
// - timer 0 split: low byte own controls, high byte clock count on timer 1 run and flag.
// - with timer 0 split, timer 1 runs outside its mode 3 and feeds baud ticks.
// - timer 2 overflow flag set on overflow, never in baud mode, software clears.
// - timer 2 external flag set by trigger falling edge capture or reload when enabled.
// - control bits 5 and 4 pick timer 2 or timer 1 as rx and tx clock.
// - control bit 3 enables trigger edges; while timer 2 clocks the serial port they only set the external flag.
// - control bit 2 runs timer 2; cleared means off.
// - control bit 1 picks count pin events or core clock for timer 2.
// - control bit 0 picks capture or reload; baud mode forces overflow reload.
// - mode: reload, capture, or baud when a serial select is set.
// - autoreload rollover sets overflow flag and loads the reload pair.
// - autoreload with enable: trigger falling edge reloads and sets external flag.
// - capture with enable: trigger falling edge copies count into reload pair, sets flag.
// - timer 0/1 flags clear when the core vectors to their service routine.
// - timer mode counts every core clock, no prescaler.
// - in baud mode the trigger edge still sets the external flag.
module ttc_timer_unit (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_tmr0_count_pin,
    input wire logic i_tmr1_count_pin,
    input wire logic i_ext_gate_pin_zero,
    input wire logic i_ext_gate_pin_one,
    input wire logic i_tmr2_count_pin,
    input wire logic i_tmr2_ext_trigger_pin,
    input wire logic i_tmr0_int_ack,
    input wire logic i_tmr1_int_ack,
    output logic o_tmr0_overflow_flag,
    output logic o_tmr1_overflow_flag,
    output logic o_tmr2_overflow_flag,
    output logic o_tmr2_external_flag,
    output logic o_tx_baud_tick,
    output logic o_rx_baud_tick
);
    import ttc_pkg::*;

    // ==========================================================
    // step of timer 0/1 in modes 0..2, low byte only in mode 3
    // result is {overflow, high byte, low byte}
    function automatic logic [16:0] ttc_step(input logic [1:0] mode, input logic [7:0] th, input logic [7:0] tl);
        logic [12:0] c13;
        logic [15:0] c16;
        c13 = {th, tl[4:0]};
        c16 = {th, tl};
        unique case (mode)
            TTC_MODE_13BIT: begin
                ttc_step = {&c13, th, tl};
                c13 = c13 + 13'h0001;
                ttc_step[15:0] = {c13[12:5], tl[7:5], c13[4:0]};
            end
            TTC_MODE_16BIT: begin
                ttc_step = {&c16, c16 + 16'h0001};
            end
            TTC_MODE_8BIT_RELOAD: begin
                ttc_step = {&tl, th, ((&tl) ? th : tl + 8'h01)};
            end
            default: begin
                ttc_step = {&tl, th, tl + 8'h01};
            end
        endcase
    endfunction

    // ==========================================================
    // registers
    logic [7:0] timer_control_ff;
    logic [7:0] timer_mode_config_ff;
    logic [7:0] tl0_ff;
    logic [7:0] th0_ff;
    logic [7:0] tl1_ff;
    logic [7:0] th1_ff;
    logic [7:0] tmr2_control_ff;
    logic [7:0] rcapl_ff;
    logic [7:0] rcaph_ff;
    logic [7:0] tl2_ff;
    logic [7:0] th2_ff;
    logic [7:0] rdata_ff;
    logic tx_tick_ff;
    logic rx_tick_ff;
    logic [TTC_PIN_COUNT-1:0] pin_meta_ff;
    logic [TTC_PIN_COUNT-1:0] pin_sync_ff;
    logic [TTC_PIN_COUNT-1:0] pin_prev_ff;

    // ==========================================================
    // pin sampling
    // two stage synchroniser, then one more stage for edges
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            pin_prev_ff <= '0;
        end else begin
            pin_meta_ff <= {i_tmr2_ext_trigger_pin, i_tmr2_count_pin, i_ext_gate_pin_one,
                            i_ext_gate_pin_zero, i_tmr1_count_pin, i_tmr0_count_pin};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    logic [TTC_PIN_COUNT-1:0] pin_fall;
    assign pin_fall = pin_prev_ff & ~pin_sync_ff;

    // ==========================================================
    // register write decode
    logic wr_timer_control, wr_timer_mode_config, wr_tl0, wr_th0, wr_tl1, wr_th1;
    logic wr_tmr2_control, wr_rcapl, wr_rcaph, wr_tl2, wr_th2;
    assign wr_timer_control = i_wr && (i_addr == TTC_ADDR_TIMER_CONTROL);
    assign wr_timer_mode_config = i_wr && (i_addr == TTC_ADDR_TIMER_MODE_CONFIG);
    assign wr_tl0 = i_wr && (i_addr == TTC_ADDR_TMR0_LOW_BYTE);
    assign wr_th0 = i_wr && (i_addr == TTC_ADDR_TMR0_HIGH_BYTE);
    assign wr_tl1 = i_wr && (i_addr == TTC_ADDR_TMR1_LOW_BYTE);
    assign wr_th1 = i_wr && (i_addr == TTC_ADDR_TMR1_HIGH_BYTE);
    assign wr_tmr2_control = i_wr && (i_addr == TTC_ADDR_TMR2_CONTROL);
    assign wr_rcapl = i_wr && (i_addr == TTC_ADDR_TMR2_RELOAD_LOW);
    assign wr_rcaph = i_wr && (i_addr == TTC_ADDR_TMR2_RELOAD_HIGH);
    assign wr_tl2 = i_wr && (i_addr == TTC_ADDR_TMR2_LOW_BYTE);
    assign wr_th2 = i_wr && (i_addr == TTC_ADDR_TMR2_HIGH_BYTE);

    // ==========================================================
    // timer 0 and timer 1 count enables
    logic [1:0] t0_mode, t1_mode;
    logic t0_split, tr0, tr1;
    logic t0_tick, t1_tick, t1_en, th0_tick;
    logic [16:0] t0_step, t1_step;
    logic t0_ovf, t1_ovf, th0_ovf;
    assign t0_mode = timer_mode_config_ff[TTC_TM_MODE_LSB +: 2];
    assign t1_mode = timer_mode_config_ff[TTC_TM_TMR1_SHIFT + TTC_TM_MODE_LSB +: 2];
    assign t0_split = (t0_mode == TTC_MODE_SPLIT);
    assign tr0 = timer_control_ff[TTC_TC_TMR0_RUN];
    assign tr1 = timer_control_ff[TTC_TC_TMR1_RUN];
    // gated enable, each tick one core clock or one pin falling edge
    assign t0_tick = tr0 && (!timer_mode_config_ff[TTC_TM_GATE] || pin_sync_ff[TTC_PIN_GATE_ZERO])
                     && (timer_mode_config_ff[TTC_TM_COUNTER_SELECT] ? pin_fall[TTC_PIN_TMR0_COUNT] : 1'b1);
    // split timer 0 owns timer 1's run bit; timer 1 then runs outside mode 3
    assign t1_en = (t1_mode == TTC_MODE_SPLIT) ? 1'b0
                   : ((t0_split || tr1)
                      && (!timer_mode_config_ff[TTC_TM_TMR1_SHIFT + TTC_TM_GATE] || pin_sync_ff[TTC_PIN_GATE_ONE]));
    assign t1_tick = t1_en
                     && (timer_mode_config_ff[TTC_TM_TMR1_SHIFT + TTC_TM_COUNTER_SELECT] ? pin_fall[TTC_PIN_TMR1_COUNT] : 1'b1);
    assign th0_tick = t0_split && tr1;
    assign t0_step = ttc_step(t0_mode, th0_ff, tl0_ff);
    assign t1_step = ttc_step(t1_mode, th1_ff, tl1_ff);
    assign t0_ovf = t0_tick && t0_step[16];
    assign t1_ovf = t1_tick && t1_step[16];
    assign th0_ovf = th0_tick && (&th0_ff);

    // ==========================================================
    // timer 0 count bytes, writes first
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tl0_ff <= TTC_RESET_BYTE;
        end else if (wr_tl0) begin
            tl0_ff <= i_wdata;
        end else if (t0_tick) begin
            tl0_ff <= t0_step[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            th0_ff <= TTC_RESET_BYTE;
        end else if (wr_th0) begin
            th0_ff <= i_wdata;
        end else if (th0_tick) begin
            th0_ff <= th0_ff + 8'h01;
        end else if (t0_tick && !t0_split) begin
            th0_ff <= t0_step[15:8];
        end
    end

    // timer 1 count bytes
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tl1_ff <= TTC_RESET_BYTE;
            th1_ff <= TTC_RESET_BYTE;
        end else begin
            if (wr_tl1) begin
                tl1_ff <= i_wdata;
            end else if (t1_tick) begin
                tl1_ff <= t1_step[7:0];
            end
            if (wr_th1) begin
                th1_ff <= i_wdata;
            end else if (t1_tick) begin
                th1_ff <= t1_step[15:8];
            end
        end
    end

    // ==========================================================
    // timer control and mode registers
    // flags: hardware set beats software write and acknowledge clear
    logic tf0_set, tf1_set;
    assign tf0_set = t0_ovf;
    assign tf1_set = t0_split ? th0_ovf : t1_ovf;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            timer_control_ff <= TTC_RESET_BYTE;
            timer_mode_config_ff <= TTC_RESET_BYTE;
        end else begin
            if (wr_timer_control) begin
                timer_control_ff <= i_wdata;
            end
            timer_control_ff[TTC_TC_TMR0_OVERFLOW_FLAG] <= tf0_set
                || (wr_timer_control ? i_wdata[TTC_TC_TMR0_OVERFLOW_FLAG]
                            : (timer_control_ff[TTC_TC_TMR0_OVERFLOW_FLAG] && !i_tmr0_int_ack));
            timer_control_ff[TTC_TC_TMR1_OVERFLOW_FLAG] <= tf1_set
                || (wr_timer_control ? i_wdata[TTC_TC_TMR1_OVERFLOW_FLAG]
                            : (timer_control_ff[TTC_TC_TMR1_OVERFLOW_FLAG] && !i_tmr1_int_ack));
            if (wr_timer_mode_config) begin
                timer_mode_config_ff <= i_wdata;
            end
        end
    end

    // ==========================================================
    // timer 2 mode decode
    logic t2_run, t2_baud, t2_capture, t2_tick, t2_ovf, t2_trig;
    assign t2_run = tmr2_control_ff[TTC_T2_RUN];
    assign t2_baud = tmr2_control_ff[TTC_T2_RX_CLOCK_FROM_TMR2] || tmr2_control_ff[TTC_T2_TX_CLOCK_FROM_TMR2];
    assign t2_capture = tmr2_control_ff[TTC_T2_CAPTURE_SELECT] && !t2_baud;
    assign t2_tick = t2_run
                     && (tmr2_control_ff[TTC_T2_COUNTER_SELECT] ? pin_fall[TTC_PIN_TMR2_COUNT] : 1'b1);
    assign t2_ovf = t2_tick && (&{th2_ff, tl2_ff});
    // trigger edge while running and enabled
    assign t2_trig = t2_run && tmr2_control_ff[TTC_T2_EXT_ENABLE] && pin_fall[TTC_PIN_TMR2_TRIGGER];

    // timer 2 count, reload on overflow outside capture or on trigger in reload mode
    logic t2_load;
    logic [15:0] t2_next;
    assign t2_load = (t2_ovf && !t2_capture)
                     || (t2_trig && !t2_baud && !t2_capture);
    assign t2_next = t2_load ? {rcaph_ff, rcapl_ff} : ({th2_ff, tl2_ff} + 16'h0001);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tl2_ff <= TTC_RESET_BYTE;
            th2_ff <= TTC_RESET_BYTE;
        end else begin
            if (wr_tl2) begin
                tl2_ff <= i_wdata;
            end else if (t2_tick || t2_load) begin
                tl2_ff <= t2_next[7:0];
            end
            if (wr_th2) begin
                th2_ff <= i_wdata;
            end else if (t2_tick || t2_load) begin
                th2_ff <= t2_next[15:8];
            end
        end
    end

    // reload pair, captured count on trigger in capture mode
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rcapl_ff <= TTC_RESET_BYTE;
            rcaph_ff <= TTC_RESET_BYTE;
        end else begin
            if (wr_rcapl) begin
                rcapl_ff <= i_wdata;
            end else if (t2_trig && t2_capture) begin
                rcapl_ff <= tl2_ff;
            end
            if (wr_rcaph) begin
                rcaph_ff <= i_wdata;
            end else if (t2_trig && t2_capture) begin
                rcaph_ff <= th2_ff;
            end
        end
    end

    // timer 2 control, flags set beats software
    logic tf2_set, tmr2_external_flag_set;
    assign tf2_set = t2_ovf && !t2_baud;
    assign tmr2_external_flag_set = t2_trig;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tmr2_control_ff <= TTC_RESET_BYTE;
        end else begin
            if (wr_tmr2_control) begin
                tmr2_control_ff <= i_wdata;
            end
            tmr2_control_ff[TTC_T2_OVERFLOW_FLAG] <= tf2_set
                || (wr_tmr2_control ? i_wdata[TTC_T2_OVERFLOW_FLAG] : tmr2_control_ff[TTC_T2_OVERFLOW_FLAG]);
            tmr2_control_ff[TTC_T2_EXTERNAL_FLAG] <= tmr2_external_flag_set
                || (wr_tmr2_control ? i_wdata[TTC_T2_EXTERNAL_FLAG] : tmr2_control_ff[TTC_T2_EXTERNAL_FLAG]);
        end
    end

    // ==========================================================
    // baud ticks to the serial port, timer 1 or timer 2 overflow
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tx_tick_ff <= 1'b0;
            rx_tick_ff <= 1'b0;
        end else begin
            tx_tick_ff <= tmr2_control_ff[TTC_T2_TX_CLOCK_FROM_TMR2] ? t2_ovf : t1_ovf;
            rx_tick_ff <= tmr2_control_ff[TTC_T2_RX_CLOCK_FROM_TMR2] ? t2_ovf : t1_ovf;
        end
    end

    // ==========================================================
    // read port, data valid only the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_rd) begin
            rdata_ff <= TTC_RESET_BYTE;
        end else begin
            unique case (i_addr)
                TTC_ADDR_TIMER_CONTROL: rdata_ff <= timer_control_ff;
                TTC_ADDR_TIMER_MODE_CONFIG: rdata_ff <= timer_mode_config_ff;
                TTC_ADDR_TMR0_LOW_BYTE: rdata_ff <= tl0_ff;
                TTC_ADDR_TMR0_HIGH_BYTE: rdata_ff <= th0_ff;
                TTC_ADDR_TMR1_LOW_BYTE: rdata_ff <= tl1_ff;
                TTC_ADDR_TMR1_HIGH_BYTE: rdata_ff <= th1_ff;
                TTC_ADDR_TMR2_CONTROL: rdata_ff <= tmr2_control_ff;
                TTC_ADDR_TMR2_RELOAD_LOW: rdata_ff <= rcapl_ff;
                TTC_ADDR_TMR2_RELOAD_HIGH: rdata_ff <= rcaph_ff;
                TTC_ADDR_TMR2_LOW_BYTE: rdata_ff <= tl2_ff;
                TTC_ADDR_TMR2_HIGH_BYTE: rdata_ff <= th2_ff;
                default: rdata_ff <= TTC_RESET_BYTE;
            endcase
        end
    end

    // outputs straight from flops
    assign o_rdata = rdata_ff;
    assign o_tmr0_overflow_flag = timer_control_ff[TTC_TC_TMR0_OVERFLOW_FLAG];
    assign o_tmr1_overflow_flag = timer_control_ff[TTC_TC_TMR1_OVERFLOW_FLAG];
    assign o_tmr2_overflow_flag = tmr2_control_ff[TTC_T2_OVERFLOW_FLAG];
    assign o_tmr2_external_flag = tmr2_control_ff[TTC_T2_EXTERNAL_FLAG];
    assign o_tx_baud_tick = tx_tick_ff;
    assign o_rx_baud_tick = rx_tick_ff;

    // ==========================================================
    // checks
    chk_t0_wrap_flag: assert property (@(posedge i_clk) disable iff (i_reset)
        (t0_mode == TTC_MODE_16BIT && t0_tick && th0_ff == 8'hff && tl0_ff == 8'hff && !wr_tl0 && !wr_th0)
        |=> (o_tmr0_overflow_flag && tl0_ff == 8'h00 && th0_ff == 8'h00))
        else $error("timer 0 wrap did not set flag or clear count");
    chk_t0_stop_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (!tr0 && !wr_tl0 && !wr_th0 && !t0_split) |=> $stable(tl0_ff) && $stable(th0_ff))
        else $error("timer 0 moved while stopped");
    chk_t0_mode2_reload: assert property (@(posedge i_clk) disable iff (i_reset)
        (t0_mode == TTC_MODE_8BIT_RELOAD && t0_tick && tl0_ff == 8'hff && !wr_tl0 && !wr_th0)
        |=> (tl0_ff == $past(th0_ff) && $stable(th0_ff)))
        else $error("mode 2 reload wrong");
    chk_t1_split_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (t1_mode == TTC_MODE_SPLIT && !wr_tl1 && !wr_th1) |=> $stable({th1_ff, tl1_ff}))
        else $error("timer 1 counted in mode 3");
    chk_t2_baud_noflag: assert property (@(posedge i_clk) disable iff (i_reset)
        (t2_baud && !o_tmr2_overflow_flag && !wr_tmr2_control) |=> !o_tmr2_overflow_flag)
        else $error("timer 2 overflow flag set in baud mode");
    chk_t2_auto_reload: assert property (@(posedge i_clk) disable iff (i_reset)
        (t2_ovf && !t2_capture && !t2_baud && !wr_tl2 && !wr_th2 && !wr_tmr2_control)
        |=> ({th2_ff, tl2_ff} == $past({rcaph_ff, rcapl_ff}) && o_tmr2_overflow_flag))
        else $error("timer 2 rollover did not reload");
    chk_t2_capture_copy: assert property (@(posedge i_clk) disable iff (i_reset)
        (t2_trig && t2_capture && !wr_rcapl && !wr_rcaph && !wr_tmr2_control)
        |=> ({rcaph_ff, rcapl_ff} == $past({th2_ff, tl2_ff}) && o_tmr2_external_flag))
        else $error("timer 2 capture missed");
    chk_t2_off_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (!t2_run && !wr_tl2 && !wr_th2) [*2] |=> $stable({th2_ff, tl2_ff}))
        else $error("timer 2 counted while off");
    chk_t0_ack_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_tmr0_int_ack && !tf0_set && !wr_timer_control) |=> !o_tmr0_overflow_flag)
        else $error("acknowledge did not clear timer 0 flag");
    chk_write_wins: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_tl2 |=> tl2_ff == $past(i_wdata))
        else $error("write to timer 2 low byte lost");
endmodule
`default_nettype wire

// [ttc_pkg.sv]
// ==========================================================
// constants of the triple timer/counter unit
package ttc_pkg;
    // register offsets on the special function register port
    localparam logic [7:0] TTC_ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] TTC_ADDR_TIMER_MODE_CONFIG = 8'h89;
    localparam logic [7:0] TTC_ADDR_TMR0_LOW_BYTE = 8'h8a;
    localparam logic [7:0] TTC_ADDR_TMR1_LOW_BYTE = 8'h8b;
    localparam logic [7:0] TTC_ADDR_TMR0_HIGH_BYTE = 8'h8c;
    localparam logic [7:0] TTC_ADDR_TMR1_HIGH_BYTE = 8'h8d;
    localparam logic [7:0] TTC_ADDR_TMR2_CONTROL = 8'hc8;
    localparam logic [7:0] TTC_ADDR_TMR2_RELOAD_LOW = 8'hca;
    localparam logic [7:0] TTC_ADDR_TMR2_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] TTC_ADDR_TMR2_LOW_BYTE = 8'hcc;
    localparam logic [7:0] TTC_ADDR_TMR2_HIGH_BYTE = 8'hcd;
    // values after reset
    localparam logic [7:0] TTC_RESET_BYTE = 8'h00;
    // timer_control fields
    localparam int TTC_TC_TMR1_OVERFLOW_FLAG = 7;
    localparam int TTC_TC_TMR1_RUN = 6;
    localparam int TTC_TC_TMR0_OVERFLOW_FLAG = 5;
    localparam int TTC_TC_TMR0_RUN = 4;
    // timer_mode_config fields, timer 1 in the upper nibble
    localparam int TTC_TM_GATE = 3;
    localparam int TTC_TM_COUNTER_SELECT = 2;
    localparam int TTC_TM_MODE_LSB = 0;
    localparam int TTC_TM_TMR1_SHIFT = 4;
    // tmr2_control fields
    localparam int TTC_T2_OVERFLOW_FLAG = 7;
    localparam int TTC_T2_EXTERNAL_FLAG = 6;
    localparam int TTC_T2_RX_CLOCK_FROM_TMR2 = 5;
    localparam int TTC_T2_TX_CLOCK_FROM_TMR2 = 4;
    localparam int TTC_T2_EXT_ENABLE = 3;
    localparam int TTC_T2_RUN = 2;
    localparam int TTC_T2_COUNTER_SELECT = 1;
    localparam int TTC_T2_CAPTURE_SELECT = 0;
    // timer 0/1 modes
    localparam logic [1:0] TTC_MODE_13BIT = 2'h0;
    localparam logic [1:0] TTC_MODE_16BIT = 2'h1;
    localparam logic [1:0] TTC_MODE_8BIT_RELOAD = 2'h2;
    localparam logic [1:0] TTC_MODE_SPLIT = 2'h3;
    // bit positions of the external pins in the sampled pin vector
    localparam int TTC_PIN_TMR0_COUNT = 0;
    localparam int TTC_PIN_TMR1_COUNT = 1;
    localparam int TTC_PIN_GATE_ZERO = 2;
    localparam int TTC_PIN_GATE_ONE = 3;
    localparam int TTC_PIN_TMR2_COUNT = 4;
    localparam int TTC_PIN_TMR2_TRIGGER = 5;
    localparam int TTC_PIN_COUNT = 6;
    // core clock
    localparam int TTC_CLK_PERIOD_NS = 100;
endpackage

// [ttc_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// far side: external count, gate and trigger pins
module ttc_pin_model (
    input wire logic i_clk,
    output logic o_count0,
    output logic o_count1,
    output logic o_gate0,
    output logic o_gate1,
    output logic o_count2,
    output logic o_trigger
);
    // count and trigger idle high, gate one held low to block timer 1
    initial {o_count0, o_count1, o_gate0, o_gate1, o_count2, o_trigger} = 6'h3b;

    // falling edges on the count pin (sel 0) or trigger pin (sel 1)
    // low level held four clocks, high level at least four, longer than the pin synchroniser
    task automatic pulse(input int sel, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            if (sel == 0) o_count2 <= 1'b0;
            else o_trigger <= 1'b0;
            repeat (4) @(posedge i_clk);
            if (sel == 0) o_count2 <= 1'b1;
            else o_trigger <= 1'b1;
            repeat (4) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
// ==========================================================
// self-checking bench of the timer/counter unit
module tb_top;
    import ttc_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_tmr0_int_ack = 1'b0;
    logic i_tmr1_int_ack = 1'b0;
    logic [7:0] o_rdata;
    logic f0, f1, f2, fx, tx, rx, c0, c1, g0, g1, c2, tr;
    int n_mismatch = 0, n_checks = 0, n_tx = 0, n_rx = 0, cyc = 0, t0;
    // rows: address, write data, read-back value
    logic [23:0] rows [11] = '{24'h8a5a5a, 24'h8ba5a5, 24'h8c3c3c, 24'h8dc3c3, 24'h892222, 24'h880f0f,
        24'hc80808, 24'hca1111, 24'hcb2222, 24'hcc3333, 24'h905a00};
    logic [7:0] tlv [3] = '{8'h1f, 8'hff, 8'hff};
    logic [7:0] thv [3] = '{8'hff, 8'hff, 8'hab};

    ttc_pin_model u_pins (.i_clk(i_clk), .o_count0(c0), .o_count1(c1), .o_gate0(g0), .o_gate1(g1),
        .o_count2(c2), .o_trigger(tr));
    ttc_timer_unit DUT (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_tmr0_count_pin(c0), .i_tmr1_count_pin(c1), .i_ext_gate_pin_zero(g0),
        .i_ext_gate_pin_one(g1), .i_tmr2_count_pin(c2), .i_tmr2_ext_trigger_pin(tr),
        .i_tmr0_int_ack(i_tmr0_int_ack), .i_tmr1_int_ack(i_tmr1_int_ack), .o_tmr0_overflow_flag(f0),
        .o_tmr1_overflow_flag(f1), .o_tmr2_overflow_flag(f2), .o_tmr2_external_flag(fx),
        .o_tx_baud_tick(tx), .o_rx_baud_tick(rx));

    // core clock, tick counter and hang guard
    always #(TTC_CLK_PERIOD_NS / 2) i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (tx === 1'b1) n_tx++;
        if (rx === 1'b1) n_rx++;
        if (cyc == 6000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        // reset value, write and read back, unmapped place reads zero
        foreach (rows[i]) begin
            rd(rows[i][23:16], 8'h00);
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        // timer 0 wrap in modes 0, 1 and 2, flag cleared by acknowledge
        for (int m = 0; m < 3; m++) begin
            wr(TTC_ADDR_TMR0_LOW_BYTE, tlv[m]);
            wr(TTC_ADDR_TMR0_HIGH_BYTE, thv[m]);
            wr(TTC_ADDR_TIMER_MODE_CONFIG, 8'(m));
            wr(TTC_ADDR_TIMER_CONTROL, 8'h10);
            repeat (3) @(posedge i_clk);
            #1;
            `CHK(f0, 1'b1)
            @(posedge i_clk);
            i_tmr0_int_ack <= 1'b1;
            @(posedge i_clk);
            i_tmr0_int_ack <= 1'b0;
            #1;
            `CHK(f0, 1'b0)
            wr(TTC_ADDR_TIMER_CONTROL, 8'h00);
            rd(TTC_ADDR_TMR0_HIGH_BYTE, (m == 2) ? 8'hab : 8'h00);
        end
        // timer 2 counts five pin edges, trigger captures them
        wr(TTC_ADDR_TMR2_CONTROL, 8'h00);
        wr(TTC_ADDR_TMR2_LOW_BYTE, 8'h00);
        wr(TTC_ADDR_TMR2_HIGH_BYTE, 8'h00);
        wr(TTC_ADDR_TMR2_CONTROL, 8'h0f);
        u_pins.pulse(0, 5);
        u_pins.pulse(1, 1);
        rd(TTC_ADDR_TMR2_RELOAD_LOW, 8'h05);
        rd(TTC_ADDR_TMR2_RELOAD_HIGH, 8'h00);
        `CHK(fx, 1'b1)
        // trigger reload in autoreload mode
        wr(TTC_ADDR_TMR2_RELOAD_LOW, 8'h34);
        wr(TTC_ADDR_TMR2_RELOAD_HIGH, 8'h12);
        wr(TTC_ADDR_TMR2_CONTROL, 8'h0e);
        u_pins.pulse(1, 1);
        rd(TTC_ADDR_TMR2_LOW_BYTE, 8'h34);
        rd(TTC_ADDR_TMR2_HIGH_BYTE, 8'h12);
        `CHK(fx, 1'b1)
        // stopped timer ignores edges, running one overflows and reloads
        wr(TTC_ADDR_TMR2_CONTROL, 8'h02);
        wr(TTC_ADDR_TMR2_LOW_BYTE, 8'hff);
        wr(TTC_ADDR_TMR2_HIGH_BYTE, 8'hff);
        u_pins.pulse(0, 1);
        rd(TTC_ADDR_TMR2_LOW_BYTE, 8'hff);
        wr(TTC_ADDR_TMR2_CONTROL, 8'h06);
        u_pins.pulse(0, 1);
        u_pins.pulse(1, 1);
        `CHK(f2, 1'b1)
        `CHK(fx, 1'b0)
        rd(TTC_ADDR_TMR2_LOW_BYTE, 8'h34);
        // baud mode: tick without overflow flag, forced reload
        wr(TTC_ADDR_TMR2_CONTROL, 8'h00);
        wr(TTC_ADDR_TMR2_LOW_BYTE, 8'hff);
        wr(TTC_ADDR_TMR2_HIGH_BYTE, 8'hff);
        t0 = n_tx;
        wr(TTC_ADDR_TMR2_CONTROL, 8'h17);
        u_pins.pulse(0, 1);
        `CHK(f2, 1'b0)
        `CHK(n_tx - t0, 1)
        rd(TTC_ADDR_TMR2_LOW_BYTE, 8'h34);
        // timer 1 gated, gate pin low holds the count
        wr(TTC_ADDR_TMR1_LOW_BYTE, 8'h00);
        wr(TTC_ADDR_TIMER_MODE_CONFIG, 8'h90);
        wr(TTC_ADDR_TIMER_CONTROL, 8'h40);
        repeat (10) @(posedge i_clk);
        rd(TTC_ADDR_TMR1_LOW_BYTE, 8'h00);
        // timer 0 split: high byte uses timer 1 run and flag, timer 1 feeds receive ticks
        wr(TTC_ADDR_TIMER_CONTROL, 8'h00);
        wr(TTC_ADDR_TMR1_LOW_BYTE, 8'h1f);
        wr(TTC_ADDR_TMR1_HIGH_BYTE, 8'hff);
        wr(TTC_ADDR_TMR0_HIGH_BYTE, 8'hfe);
        t0 = n_rx;
        wr(TTC_ADDR_TIMER_MODE_CONFIG, 8'h03);
        wr(TTC_ADDR_TIMER_CONTROL, 8'h40);
        repeat (3) @(posedge i_clk);
        #1;
        `CHK(f1, 1'b1)
        `CHK(n_rx - t0, 1)
        @(posedge i_clk);
        i_tmr1_int_ack <= 1'b1;
        @(posedge i_clk);
        i_tmr1_int_ack <= 1'b0;
        #1;
        `CHK(f1, 1'b0)
        conclude();
    end
endmodule
`default_nettype wire
